// ===== hw/afesp_pkg.sv
/*
  afesp_pkg: constants, field positions and types of the front-end status,
  tone-detector and power-mode block.
  assumes: included by name as afesp_pkg:: everywhere, nothing imported.
*/
// Notes on behaviour
// - receive clipping sets status bit 14; it resets to 0
// - transmit clipping sets status bit 13; it resets to 0
// - a clipping flag clears only when the controller writes 0 there or writes 1 to bit 9
// - bit 12 enables the tone detector during power down; default off
// - bit 11 picks the tone: 0 tone 40, 1 tone 72
// - bit 10 low: serial output floats, select pin ignored, every access writes
// - bit 10 high: select pin honoured, reads return the addressed register serially; here any address other than 111 reads back as 000
// - writing 1 to bit 9 restores every control register default; here only the word at 111 is reset, by a write to 111
// - tone detector runs only with suspend 1 and power-down 0
// - detector active and selected tone heard raises the wake output
// - wake output drops once suspend and power-down are both 0
// - suspend 0, power-down 0: fully powered, detector off, master clock on
// - suspend 0, power-down 1: analog off, digital on, master clock on
// - suspend 1, power-down 0: analog and digital off, detector on if bit 12 set, clock off
// - suspend 1, power-down 1: full standby, master clock off
// - received samples leave as four 4-bit nibbles per word period, low nibble first
// - status and tone settings live at control address 111
// - access is start 0, twelve data, three address bits, then stop 1
package afesp_pkg;
  localparam int unsigned DATA_LSB    = 3;
  localparam int unsigned POS_RXCLIP  = 14;
  localparam int unsigned POS_TXCLIP  = 13;
  localparam int unsigned POS_SLEEP   = 12;
  localparam int unsigned POS_TONESEL = 11;
  localparam int unsigned POS_DEBUG   = 10;
  localparam int unsigned POS_SWRST   = 9;
  localparam int unsigned REG_BITS    = 12;
  localparam int unsigned ADDR_BITS   = 3;
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned NIB_BITS    = 4;
  localparam logic [2:0]  STAT_ADDR   = 3'h7;
  localparam logic [11:0] STAT_RST    = 12'h000;
  localparam logic [1:0]  WCLK_RISE   = 2'h1;
  localparam logic [1:0]  WCLK_HOLD   = 2'h2;
  localparam logic [1:0]  SAMPLE_PH   = 2'h3;
  localparam logic [3:0]  LAST_SHIFT  = 4'he;
  localparam logic [4:0]  OUT_BITS    = 5'h10;
  localparam logic        START_LVL   = 1'b0;
  localparam logic        STOP_LVL    = 1'b1;

  typedef enum logic [3:0] {
    PM_ACTIVE  = 4'h1,
    PM_ENUM    = 4'h2,
    PM_SUSPEND = 4'h4,
    PM_STANDBY = 4'h8
  } afesp_pmode_type;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h1,
    RX_SHIFT = 3'h2,
    RX_STOP  = 3'h4
  } afesp_rxst_type;

  function automatic afesp_pmode_type afesp_mode_of(input logic sus, input logic power_off_pin);
    if (!sus && !power_off_pin) begin
      return PM_ACTIVE;
    end else if (!sus) begin
      return PM_ENUM;
    end else if (!power_off_pin) begin
      return PM_SUSPEND;
    end else begin
      return PM_STANDBY;
    end
  endfunction
endpackage

// ===== hw/afesp_link_if.sv
/*
  afesp_link_if: carrier between the link-clock serial front and the core.
  assumes: each toggle changes only after its data fields are stable.
*/
`timescale 1ns/10ps
interface afesp_link_if;
  logic        wr_tgl;
  logic [11:0] wr_data;
  logic [2:0]  wr_addr;
  logic        rd_tgl;
  logic [2:0]  rd_addr;
  logic        ack_tgl;
  logic [11:0] rd_data;
  logic        debug_en;
  modport link (output wr_tgl, wr_data, wr_addr, rd_tgl, rd_addr,
                input ack_tgl, rd_data, debug_en);
  modport core (input wr_tgl, wr_data, wr_addr, rd_tgl, rd_addr,
                output ack_tgl, rd_data, debug_en);
endinterface

// ===== hw/afesp_link.sv
/*
  afesp_link: serial control receiver, read-back shifter, word clock and
  receive nibble stream, all on the master (link) clock.
  assumes: link_clk runs free; the far party changes bits once per word period.
*/
`timescale 1ns/10ps
module afesp_link (
  input  wire logic        link_clk,
  input  wire logic        sys_rst,
  input  wire logic        ser_in,
  input  wire logic        rw_in,
  input  wire logic [15:0] sample_in,
  output logic             word_clk,
  output logic             ser_out,
  output logic             ser_out_en,
  output logic [3:0]       nib_out,
  afesp_link_if.link       lnk
);
  typedef struct packed {
    logic                      rst_m, rst_s, dbg_m, dbg_s, ack_m, ack_s, ack_d;
    logic [1:0]                div;
    logic                      wclk;
    afesp_pkg::afesp_rxst_type st;
    logic [3:0]                cnt;
    logic [14:0]               sh;
    logic                      rw, wr_tgl, rd_tgl, rd_pend;
    logic [11:0]               wr_data;
    logic [2:0]                wr_addr, rd_addr;
    logic [15:0]               osh;
    logic [4:0]                ocnt;
    logic                      obit, oen;
    logic [15:0]               smp;
    logic [3:0]                nib;
  } afesp_lnk_type;

  afesp_lnk_type r, n;
  logic          samp;

  assign samp = (r.div == afesp_pkg::SAMPLE_PH);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n       = r;
    n.rst_m = sys_rst;
    n.rst_s = r.rst_m;
    n.dbg_m = lnk.debug_en;
    n.dbg_s = r.dbg_m;
    n.ack_m = lnk.ack_tgl;
    n.ack_s = r.ack_m;
    n.ack_d = r.ack_s;
    n.div   = r.div + 2'h1;
    n.wclk  = (r.div == afesp_pkg::WCLK_RISE) || (r.div == afesp_pkg::WCLK_HOLD);
    if (samp) begin
      case (r.st)
        afesp_pkg::RX_IDLE: begin
          if (ser_in == afesp_pkg::START_LVL) begin
            n.st  = afesp_pkg::RX_SHIFT;
            n.cnt = 4'h0;
            n.rw  = rw_in & r.dbg_s;
          end
        end
        afesp_pkg::RX_SHIFT: begin
          n.sh  = {r.sh[13:0], ser_in};
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == afesp_pkg::LAST_SHIFT) begin
            n.st = afesp_pkg::RX_STOP;
          end
        end
        afesp_pkg::RX_STOP: begin
          n.st = afesp_pkg::RX_IDLE;
          // a missing stop bit throws the burst away
          if (ser_in == afesp_pkg::STOP_LVL) begin
            if (r.rw) begin
              n.rd_tgl  = ~r.rd_tgl;
              n.rd_addr = r.sh[2:0];
              n.rd_pend = 1'b1;
            end else begin
              n.wr_tgl  = ~r.wr_tgl;
              n.wr_data = r.sh[14:3];
              n.wr_addr = r.sh[2:0];
            end
          end
        end
        default: n.st = afesp_pkg::RX_IDLE;
      endcase
      if (r.ocnt != 5'h0) begin
        n.obit = r.osh[15];
        n.osh  = {r.osh[14:0], 1'b0};
        n.ocnt = r.ocnt - 5'h1;
        n.oen  = 1'b1;
      end else begin
        n.obit = afesp_pkg::STOP_LVL;
        n.oen  = 1'b0;
      end
    end
    // read data are stable once the core's acknowledge has crossed
    if (r.rd_pend && (r.ack_s != r.ack_d)) begin
      n.rd_pend = 1'b0;
      n.osh     = {afesp_pkg::START_LVL, lnk.rd_data, r.rd_addr};
      n.ocnt    = afesp_pkg::OUT_BITS;
    end
    if (!r.dbg_s) begin
      n.oen = 1'b0;
    end
    n.smp = samp ? sample_in : r.smp;
    n.nib = samp ? sample_in[3:0] : r.smp[{2'(r.div + 2'h1), 2'b00} +: afesp_pkg::NIB_BITS];
    if (r.rst_s) begin
      n.st      = afesp_pkg::RX_IDLE;
      n.div     = 2'h0;
      n.wclk    = 1'b0;
      n.cnt     = 4'h0;
      n.sh      = 15'h0000;
      n.rw      = 1'b0;
      n.wr_tgl  = 1'b0;
      n.rd_tgl  = 1'b0;
      n.rd_pend = 1'b0;
      n.wr_data = 12'h000;
      n.wr_addr = 3'h0;
      n.rd_addr = 3'h0;
      n.osh     = 16'h0000;
      n.ocnt    = 5'h00;
      n.obit    = afesp_pkg::STOP_LVL;
      n.oen     = 1'b0;
      n.smp     = 16'h0000;
      n.nib     = 4'h0;
    end
  end

  always_ff @(posedge link_clk) begin
    r <= n;
  end

  assign word_clk    = r.wclk;
  assign ser_out     = r.obit;
  assign ser_out_en  = r.oen;
  assign nib_out     = r.nib;
  assign lnk.wr_tgl  = r.wr_tgl;
  assign lnk.wr_data = r.wr_data;
  assign lnk.wr_addr = r.wr_addr;
  assign lnk.rd_tgl  = r.rd_tgl;
  assign lnk.rd_addr = r.rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_burst_end;
    r.st == afesp_pkg::RX_STOP && samp && ser_in && !r.rw;
  endsequence

  a_hiz_in_normal: assert property (@(posedge link_clk) disable iff (r.rst_s)
    !r.dbg_s |=> !r.oen) else $error("serial output driven outside debug mode");
  a_read_honoured: assert property (@(posedge link_clk) disable iff (r.rst_s)
    (r.st == afesp_pkg::RX_IDLE && samp && !ser_in && rw_in && r.dbg_s) |=> r.rw)
    else $error("read select ignored in debug mode");
  a_burst_commit: assert property (@(posedge link_clk) disable iff (r.rst_s)
    s_burst_end |=> r.wr_tgl != $past(r.wr_tgl)) else $error("valid burst not committed");
  a_word_rate: assert property (@(posedge link_clk) disable iff (r.rst_s)
    $rose(r.wclk) |-> ##4 $rose(r.wclk)) else $error("word clock not one in four");
endmodule // afesp_link

// ===== hw/afesp_top.sv
/*
  afesp_top: status and tone-setup word, clipping flags, power-mode decode,
  master clock gate and wake-up latch; serial control front instantiated.
  assumes: mode, clip and tone-level pins are asynchronous to CLOCK;
  LINK_CLK is the free-running master clock of the serial link.
*/
`timescale 1ns/10ps
module afesp_top (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        LINK_CLK,
  input  wire logic        SUSPEND_PIN,
  input  wire logic        POWER_OFF_PIN,
  input  wire logic        RX_CLIP_IN,
  input  wire logic        TX_CLIP_IN,
  input  wire logic        TONE_STD_SEEN,
  input  wire logic        TONE_ISDN_SEEN,
  input  wire logic        SERIAL_CTL_WRITE_IN,
  input  wire logic        READ_WRITE_SELECT,
  input  wire logic [15:0] RX_SAMPLE_IN,
  output logic             WAKE_INDICATOR_OUT,
  output logic             MASTER_CLOCK_OUT_EN,
  output logic             ANALOG_POWER_ON,
  output logic             DIGITAL_POWER_ON,
  output logic             TONE_DETECTOR_ON,
  output logic             TONE_SELECT,
  output logic [11:0]      STATUS_WORD,
  output logic             WORD_CLOCK_OUT,
  output logic             SERIAL_CTL_READ_OUT,
  output logic             SERIAL_CTL_READ_OUT_EN,
  output logic [3:0]       RX_NIBBLE_OUT
);
  localparam int RXI = afesp_pkg::POS_RXCLIP - afesp_pkg::DATA_LSB;
  localparam int TXI = afesp_pkg::POS_TXCLIP - afesp_pkg::DATA_LSB;
  localparam int SLI = afesp_pkg::POS_SLEEP - afesp_pkg::DATA_LSB;
  localparam int TSI = afesp_pkg::POS_TONESEL - afesp_pkg::DATA_LSB;
  localparam int DBI = afesp_pkg::POS_DEBUG - afesp_pkg::DATA_LSB;
  localparam int SRI = afesp_pkg::POS_SWRST - afesp_pkg::DATA_LSB;

  typedef struct packed {
    logic                       sus_m, sus_s, pwd_m, pwd_s;
    logic                       rxc_m, rxc_s, txc_m, txc_s;
    logic                       t40_m, t40_s, t72_m, t72_s;
    logic                       wtg_m, wtg_s, wtg_d;
    logic                       rtg_m, rtg_s, rtg_d;
    logic                       ack;
    logic [11:0]                snap;
    logic [11:0]                stat;
    afesp_pkg::afesp_pmode_type mode;
    logic                       apwr, dpwr, mclk, tdon, wake;
  } afesp_core_type;

  afesp_core_type r, n;
  logic           wr_ev;
  logic           rd_ev;
  logic           hit;

  afesp_link_if lnk ();

  afesp_link afesp_link_inst (
    .link_clk   (LINK_CLK),
    .sys_rst    (SYS_RST),
    .ser_in     (SERIAL_CTL_WRITE_IN),
    .rw_in      (READ_WRITE_SELECT),
    .sample_in  (RX_SAMPLE_IN),
    .word_clk   (WORD_CLOCK_OUT),
    .ser_out    (SERIAL_CTL_READ_OUT),
    .ser_out_en (SERIAL_CTL_READ_OUT_EN),
    .nib_out    (RX_NIBBLE_OUT),
    .lnk        (lnk.link)
  );

  // writes to other addresses belong to registers outside this block
  assign wr_ev = (r.wtg_s != r.wtg_d) && (lnk.wr_addr == afesp_pkg::STAT_ADDR);
  assign rd_ev = (r.rtg_s != r.rtg_d);
  assign hit   = r.stat[TSI] ? r.t72_s : r.t40_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n       = r;
    n.sus_m = SUSPEND_PIN;
    n.sus_s = r.sus_m;
    n.pwd_m = POWER_OFF_PIN;
    n.pwd_s = r.pwd_m;
    n.rxc_m = RX_CLIP_IN;
    n.rxc_s = r.rxc_m;
    n.txc_m = TX_CLIP_IN;
    n.txc_s = r.txc_m;
    n.t40_m = TONE_STD_SEEN;
    n.t40_s = r.t40_m;
    n.t72_m = TONE_ISDN_SEEN;
    n.t72_s = r.t72_m;
    n.wtg_m = lnk.wr_tgl;
    n.wtg_s = r.wtg_m;
    n.wtg_d = r.wtg_s;
    n.rtg_m = lnk.rd_tgl;
    n.rtg_s = r.rtg_m;
    n.rtg_d = r.rtg_s;
    if (rd_ev) begin
      n.snap = (lnk.rd_addr == afesp_pkg::STAT_ADDR) ? r.stat : afesp_pkg::STAT_RST;
      n.ack  = ~r.ack;
    end
    if (wr_ev) begin
      if (lnk.wr_data[SRI]) begin
        n.stat = afesp_pkg::STAT_RST;
      end else begin
        n.stat      = lnk.wr_data;
        n.stat[RXI] = r.stat[RXI] & lnk.wr_data[RXI];
        n.stat[TXI] = r.stat[TXI] & lnk.wr_data[TXI];
        n.stat[SRI] = 1'b0;
      end
    end
    // set wins over a clear arriving in the same cycle
    if (r.rxc_s) begin
      n.stat[RXI] = 1'b1;
    end
    if (r.txc_s) begin
      n.stat[TXI] = 1'b1;
    end
    n.mode = afesp_pkg::afesp_mode_of(r.sus_s, r.pwd_s);
    case (r.mode)
      afesp_pkg::PM_ACTIVE: begin
        n.apwr = 1'b1;
        n.dpwr = 1'b1;
        n.mclk = 1'b1;
        n.tdon = 1'b0;
      end
      afesp_pkg::PM_ENUM: begin
        n.apwr = 1'b0;
        n.dpwr = 1'b1;
        n.mclk = 1'b1;
        n.tdon = 1'b0;
      end
      afesp_pkg::PM_SUSPEND: begin
        n.apwr = 1'b0;
        n.dpwr = 1'b0;
        n.mclk = 1'b0;
        n.tdon = r.stat[SLI];
      end
      default: begin
        n.apwr = 1'b0;
        n.dpwr = 1'b0;
        n.mclk = 1'b0;
        n.tdon = 1'b0;
      end
    endcase
    // latched, not following the tone level, so a short burst still wakes
    if (r.mode == afesp_pkg::PM_ACTIVE) begin
      n.wake = 1'b0;
    end else if (r.tdon && hit) begin
      n.wake = 1'b1;
    end
    if (SYS_RST) begin
      n.ack  = 1'b0;
      n.snap = afesp_pkg::STAT_RST;
      n.stat = afesp_pkg::STAT_RST;
      n.mode = afesp_pkg::PM_ACTIVE;
      n.apwr = 1'b0;
      n.dpwr = 1'b0;
      n.mclk = 1'b0;
      n.tdon = 1'b0;
      n.wake = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    r <= n;
  end

  assign lnk.ack_tgl         = r.ack;
  assign lnk.rd_data         = r.snap;
  assign lnk.debug_en        = r.stat[DBI];
  assign WAKE_INDICATOR_OUT  = r.wake;
  assign MASTER_CLOCK_OUT_EN = r.mclk;
  assign ANALOG_POWER_ON     = r.apwr;
  assign DIGITAL_POWER_ON    = r.dpwr;
  assign TONE_DETECTOR_ON    = r.tdon;
  assign TONE_SELECT         = r.stat[TSI];
  assign STATUS_WORD         = r.stat;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_stat_write;
    wr_ev && !lnk.wr_data[SRI];
  endsequence

  sequence s_mode_held(logic sus, logic power_off_pin);
    (r.sus_s == sus && r.pwd_s == power_off_pin) [*2];
  endsequence

  a_rx_clip_set: assert property (r.rxc_s |=> r.stat[RXI])
    else $error("receive clip flag not set");
  a_tx_clip_set: assert property (r.txc_s |=> r.stat[TXI])
    else $error("transmit clip flag not set");
  a_clip_clear: assert property (s_stat_write ##0 (!lnk.wr_data[RXI] && !r.rxc_s)
    |=> !r.stat[RXI]) else $error("receive clip flag not cleared by zero");
  a_clip_sticky: assert property ((r.stat[TXI] && !wr_ev) |=> r.stat[TXI])
    else $error("transmit clip flag lost without a clear");
  a_sleep_gate: assert property (r.tdon |-> $past(r.stat[SLI]))
    else $error("detector on while power-down listening disabled");
  a_tone_select: assert property (s_stat_write |=> TONE_SELECT == $past(lnk.wr_data[TSI]))
    else $error("tone select not taken from write");
  a_soft_reset: assert property ((wr_ev && lnk.wr_data[SRI] && !r.rxc_s && !r.txc_s)
    |=> r.stat == afesp_pkg::STAT_RST) else $error("software reset left a field set");
  a_detect_gate: assert property (r.tdon |-> $past(r.mode) == afesp_pkg::PM_SUSPEND)
    else $error("detector on outside suspend mode");
  a_wake_set: assert property ((r.tdon && hit && r.mode != afesp_pkg::PM_ACTIVE) |=> r.wake)
    else $error("tone heard but no wake");
  a_wake_clear: assert property (s_mode_held(1'b0, 1'b0) |=> ##1 !r.wake)
    else $error("wake held in full operating mode");
  a_active_mode: assert property (s_mode_held(1'b0, 1'b0) |=> ##1 (r.mclk && r.apwr && !r.tdon))
    else $error("active mode outputs wrong");
  a_enum_mode: assert property (s_mode_held(1'b0, 1'b1) |=> ##1 (r.mclk && r.dpwr && !r.apwr))
    else $error("enumerating mode outputs wrong");
  a_suspend_mode: assert property (s_mode_held(1'b1, 1'b0) |=> ##1 (!r.mclk && !r.dpwr && !r.apwr
    && r.tdon == $past(r.stat[SLI]))) else $error("suspend mode outputs wrong");
  a_standby_mode: assert property (s_mode_held(1'b1, 1'b1) |=> ##1 (!r.mclk && !r.dpwr && !r.tdon))
    else $error("standby mode outputs wrong");
  a_wake_latch: assert property ((r.wake && r.mode != afesp_pkg::PM_ACTIVE) |=> r.wake)
    else $error("wake dropped before full operating mode");
  a_read_snap: assert property ((rd_ev && lnk.rd_addr == afesp_pkg::STAT_ADDR) |=>
    (r.snap == $past(r.stat) && r.ack != $past(r.ack))) else $error("status read not captured");
endmodule // afesp_top

// ===== tb/afesp_pump_model.sv
/*
  afesp_pump_model: data-pump side of the serial control link.
  assumes: word_clk comes from the device; ctl_pin floats while not driven.
*/
`timescale 1ns/10ps
module afesp_pump_model (
  input  wire logic link_clk,
  input  wire logic word_clk,
  input  wire logic ctl_pin,
  output logic      ser_in,
  output logic      rw_sel
);
  initial begin
    ser_in = 1'b1;
    rw_sel = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // called only while suspend is 0
  // bits change after word clock falls, so they stand a full word at the sample
  task automatic send(input logic rw, input logic [11:0] d, input logic [2:0] a,
                      input logic stp);
    logic [16:0] b;
    b = {1'b0, d, a, stp};
    for (int i = 16; i >= 0; i--) begin
      @(negedge word_clk);
      ser_in <= b[i];
      rw_sel <= (i == 16) ? rw : ~rw; // select only counts beside the start
    end
    @(negedge word_clk);
    ser_in <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read-back: wait for a driven start 0, then fifteen bits, half a link cycle after each word clock fall
  task automatic fetch(output logic [15:0] w);
    logic ok;
    ok = 1'b0;
    w = 16'hffff;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(negedge word_clk);
      @(negedge link_clk);
      ok = (ctl_pin === 1'b0);
    end
    w[15] = ~ok;
    for (int i = 14; i >= 0; i--) begin
      @(negedge word_clk);
      @(negedge link_clk);
      w[i] = ctl_pin;
    end
  endtask
endmodule // afesp_pump_model

// ===== tb/afesp_top_tb.sv
/*
  afesp_top_tb: self-checking bench for afesp_top.
  assumes: afesp_pump_model plays the data pump; other pins driven on CLOCK edges, RX_SAMPLE_IN on a LINK_CLK edge.
*/
`timescale 1ns/10ps
module afesp_top_tb;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst = 1'b1;
  logic        sus = 1'b0;
  logic        power_off_pin = 1'b0;
  logic        rxc = 1'b0;
  logic        txc = 1'b0;
  logic        tstd = 1'b0;
  logic        tisdn = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic        ser_in, rw_sel, wake, mclk, ana, dig, det, tsel, wclk, rd_out, rd_en;
  logic [11:0] status;
  logic [3:0]  nib;
  // released pin rests high, like the board's pull-up, not at its last value
  tri1         ctl_pin = rd_en ? rd_out : 1'bz;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic        en_seen;
  logic [15:0] w;
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #32 lclk = ~lclk;
  end
  afesp_top afesp_top_inst (
    .CLOCK(clk), .SYS_RST(rst), .LINK_CLK(lclk), .SUSPEND_PIN(sus),
    .POWER_OFF_PIN(power_off_pin), .RX_CLIP_IN(rxc), .TX_CLIP_IN(txc),
    .TONE_STD_SEEN(tstd), .TONE_ISDN_SEEN(tisdn), .SERIAL_CTL_WRITE_IN(ser_in),
    .READ_WRITE_SELECT(rw_sel), .RX_SAMPLE_IN(sample), .WAKE_INDICATOR_OUT(wake),
    .MASTER_CLOCK_OUT_EN(mclk), .ANALOG_POWER_ON(ana), .DIGITAL_POWER_ON(dig),
    .TONE_DETECTOR_ON(det), .TONE_SELECT(tsel), .STATUS_WORD(status),
    .WORD_CLOCK_OUT(wclk), .SERIAL_CTL_READ_OUT(rd_out),
    .SERIAL_CTL_READ_OUT_EN(rd_en), .RX_NIBBLE_OUT(nib));
  afesp_pump_model afesp_pump_model_inst (
    .link_clk(lclk), .word_clk(wclk), .ctl_pin(ctl_pin), .ser_in(ser_in),
    .rw_sel(rw_sel));
  always @(posedge lclk) if (rd_en === 1'b1) en_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a hung handshake ends here instead of running forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // write burst; the word lands a few link and core cycles after the stop bit
  task automatic wr(input logic [11:0] d, input logic [2:0] a, input logic stp);
    afesp_pump_model_inst.send(1'b0, d, a, stp);
    wt(30);
  endtask
  task automatic mode(input logic s, input logic p);
    @(posedge clk);
    sus <= s;
    power_off_pin <= p;
    wt(8);
  endtask
  function automatic logic [15:0] pwr();
    return {12'h000, ana, dig, mclk, det};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] exp_pwr [4] = '{4'he, 4'h6, 4'h0, 4'h0};
    logic [15:0] nibs;
    repeat (4) @(posedge lclk);
    @(posedge clk);
    rst <= 1'b0;
    wt(40);
    chk(status, 16'h0);
    chk(wake, 1'b0);
    for (int i = 0; i < 4; i++) begin
      mode(i[1], i[0]);
      chk(pwr(), exp_pwr[i]);
    end
    mode(1'b0, 1'b0);
    wr(12'h200, 3'h7, 1'b1);
    chk(status, 12'h200);
    mode(1'b1, 1'b0);
    chk(pwr(), 16'h1);
    @(posedge clk) tisdn <= 1'b1;
    wt(8);
    chk(wake, 1'b0);
    @(posedge clk) tstd <= 1'b1;
    wt(8);
    chk(wake, 1'b1);
    @(posedge clk) tstd <= 1'b0;
    mode(1'b1, 1'b1);
    chk(pwr(), 16'h0);
    chk(wake, 1'b1);
    mode(1'b0, 1'b1);
    chk(wake, 1'b1);
    mode(1'b0, 1'b0);
    chk(wake, 1'b0);
    @(posedge clk) tisdn <= 1'b0;
    wr(12'h300, 3'h7, 1'b1);
    chk(tsel, 1'b1);
    mode(1'b1, 1'b0);
    @(posedge clk) tisdn <= 1'b1;
    wt(8);
    chk(wake, 1'b1);
    @(posedge clk) tisdn <= 1'b0;
    mode(1'b0, 1'b0);
    @(posedge clk) rxc <= 1'b1;
    wt(6);
    @(posedge clk) rxc <= 1'b0;
    wt(10);
    chk(status, 12'hb00);
    wr(12'h300, 3'h7, 1'b1);
    chk(status, 12'h300);
    @(posedge clk) txc <= 1'b1;
    wt(6);
    @(posedge clk) txc <= 1'b0;
    wt(10);
    chk(status, 12'h700);
    wr(12'h700, 3'h7, 1'b1);
    chk(status, 12'h700);
    wr(12'h300, 3'h7, 1'b1);
    chk(status, 12'h300);
    wr(12'h0ff, 3'h3, 1'b1);
    chk(status, 12'h300);
    wr(12'h0ff, 3'h7, 1'b0);
    chk(status, 12'h300);
    en_seen = 1'b0;
    afesp_pump_model_inst.send(1'b1, 12'h03f, 3'h7, 1'b1);
    wt(300);
    chk(status, 12'h03f);
    chk(en_seen, 1'b0);
    wr(12'h0bf, 3'h7, 1'b1);
    afesp_pump_model_inst.send(1'b1, 12'h000, 3'h7, 1'b1);
    afesp_pump_model_inst.fetch(w);
    chk(w, {1'b0, 12'h0bf, 3'h7});
    wt(30);
    chk(status, 12'h0bf);
    wr(12'h0ff, 3'h7, 1'b1);
    chk(status, 12'h000);
    @(posedge lclk) sample <= 16'h4c3a;
    repeat (2) @(negedge wclk);
    for (int i = 0; i < 4; i++) begin
      @(negedge lclk);
      nibs[i*4 +: 4] = nib;
    end
    chk(nibs, 16'h4c3a);
    complete_run();
  end
endmodule // afesp_top_tb
